// ===== hdl/sdc_pkg.sv
// constants and state layout for the sync detect, clamp and green-sync unit
package sdc_pkg;
   // register byte addresses
   localparam logic [7:0] ADDR_CTRL_A      = 8'hed;
   localparam logic [7:0] ADDR_CTRL_B      = 8'hee;
   localparam logic [7:0] ADDR_CTRL_C      = 8'hef;
   localparam logic [7:0] ADDR_CLAMP_WIDTH = 8'hf0;
   localparam logic [7:0] ADDR_PIN_LEVEL   = 8'hf1;
   // sync_control_a fields
   localparam int A_SRC_SEL   = 7;
   localparam int A_SPARE     = 6;
   localparam int A_CMP_MODE  = 5;
   // sync_control_b fields
   localparam int B_HPOL      = 0;
   localparam int B_VPOL      = 1;
   localparam int B_CLAMP_POL = 4;
   // sync_control_c fields
   localparam int C_CPRES     = 1;
   localparam int C_GREEN     = 2;
   localparam int C_CNT_SRC   = 3;
   localparam int C_PSEUDO    = 4;
   localparam int C_OUT_EN    = 5;
   localparam int C_VDD_SEL   = 6;
   // pin level register fields
   localparam int P_VSYNC     = 0;
   localparam int P_HC_SEL    = 1;
   localparam int P_EXT_V     = 2;
   // reset values
   localparam logic [7:0] RST_CTRL_A  = 8'h00;
   localparam logic [7:0] RST_CTRL_B  = 8'h00;
   localparam logic [7:0] RST_CTRL_C  = 8'h20;
   localparam logic [7:0] RST_CLAMP_W = 8'h10;
   // timing
   localparam int CLK_NS        = 50;
   localparam int TICK_DIV      = 1000;
   localparam int POL_TICKS     = 16;
   localparam int SOG_DELAY_NS  = 150;
   localparam int SOG_DLY_CYC   = (SOG_DELAY_NS / CLK_NS < 1) ? 1 : SOG_DELAY_NS / CLK_NS;
   localparam int SOG_LIMIT     = 32;
   localparam int SLOW_PRESCALE = 8;
   localparam logic [9:0]  TICK_LAST  = 10'(TICK_DIV - 1);
   localparam logic [3:0]  WIN_LAST   = 4'(POL_TICKS - 1);
   localparam logic [13:0] HALF_WIN   = 14'(POL_TICKS * TICK_DIV / 2);
   localparam logic [5:0]  SOG_MAX    = 6'(SOG_LIMIT + 1);
   localparam logic [2:0]  PRESC_LAST = 3'(SLOW_PRESCALE - 1);
   localparam logic [4:0]  CNT_MAX    = 5'h1f;
   localparam logic [4:0]  CNT_MIN    = 5'h00;

   typedef struct packed {
      logic       csync;
      logic       vsync;
      logic       hsync;
   } sdc_pins_type;

   typedef struct packed {
      logic       hsync_out;
      logic       vsync_out;
      logic       clamp_out;
      logic       capture_first;
      logic       second_clk;
   } sdc_outs_type;

   typedef struct packed {
      logic [2:0]  a_ctl;
      logic [4:0]  cnt;
      logic [5:0]  b_ctl;
      logic        hpol;
      logic        vpol;
      logic [3:0]  c_ctl;
      logic        cpres;
      logic        green;
      logic [7:0]  clamp_w;
      sdc_pins_type s1;
      sdc_pins_type s2;
      sdc_pins_type s3;
      logic [SOG_DLY_CYC-1:0] c_dly;
      logic        ext_v;
      logic [5:0]  sog_cnt;
      logic [9:0]  div_cnt;
      logic [3:0]  win_cnt;
      logic [13:0] h_high;
      logic [13:0] v_high;
      logic        c_seen;
      logic [7:0]  clamp_cnt;
      logic [2:0]  presc;
      logic [7:0]  rdata;
      sdc_outs_type outs;
   } sdc_state_type;
endpackage

// ===== hdl/sdc_unit.sv
// sync presence, polarity, vsync extraction, clamp and green-sync detection
//
// Behaviour
// RQ1 - a.5=0 reads vsync; a.7 picks hsync/csync
// RQ2 - software polls pin levels for transitions
// RQ3 - vsync output edge drives first capture timer
// RQ4 - selected input clocks the second timer
// RQ5 - composite presence shown in c.1
// RQ6 - polarity judged over 16 interval ticks
// RQ7 - b.0 shows horizontal polarity
// RQ8 - b.1 shows vertical polarity
// RQ9 - vertical polarity updates after one window
// RQ10 - extracted output changes only at limits
// RQ11 - counter up on high, down on low, saturates
// RQ12 - software may use second capture for confirmation
// RQ13 - clamp pulse tied to hsync, programmable width
// RQ14 - front porch without green, else back porch
// RQ15 - b.4 sets clamp polarity
// RQ16 - csync delayed 150 ns before comparison
// RQ17 - green flag after more than 32 mismatches
// RQ18 - software sets polarity first, then polls flag
// RQ19 - c holds pseudo, source, enable, supply bits
// RQ20 - high at 11111, low at 00000, else hold
// RQ21 - counter readable in a bits 4..0
// RQ22 - all sync pins pass two flip-flops
`timescale 1ns/10ps
module sdc_unit (
   input  wire  logic                 ref_clk,
   input  wire  logic                 reset_n,
   input  wire  logic [7:0]           addr,
   input  wire  logic [7:0]           wdata,
   input  wire  logic                 wr_stb,
   input  wire  logic                 rd_stb,
   output logic [7:0]                 rdata,
   input  wire  sdc_pkg::sdc_pins_type sync_in,
   output sdc_pkg::sdc_outs_type      sync_out,
   output logic                       pseudo_en,
   output logic                       vdd_level_sel
);
   import sdc_pkg::*;

   sdc_state_type q;
   sdc_state_type d;

   logic          sel_lvl;
   logic          h_rise;
   logic          c_fall;
   logic          tick;
   logic          win_end;
   logic          cnt_step;
   logic          clamp_start;
   logic          c_dly_out;
   logic          vsel;
   logic          out_en;

   always_comb begin
      d = q;
      // two-stage pin synchronisers, third stage for edges
      // RQ22 pin synchronisers
      d.s1 = sync_in;
      d.s2 = q.s1;
      d.s3 = q.s2;

      // RQ1 direct source routing
      sel_lvl = q.a_ctl[2] ? q.s2.csync : q.s2.hsync;
      out_en  = q.c_ctl[2];

      // interval tick and polarity window
      tick    = (q.div_cnt == TICK_LAST);
      win_end = tick && (q.win_cnt == WIN_LAST);
      d.div_cnt = tick ? 10'h000 : q.div_cnt + 10'h001;
      if (tick) begin
         d.win_cnt = q.win_cnt + 4'h1;
      end
      // RQ6 high-time accumulation over window
      if (win_end) begin
         d.h_high = 14'h0000;
         d.v_high = 14'h0000;
         d.c_seen = 1'b0;
         // RQ7 horizontal polarity, mostly low is positive
         d.hpol  = (q.h_high < HALF_WIN);
         // RQ8 RQ9 vertical polarity, one window latency
         d.vpol  = (q.v_high < HALF_WIN);
         // RQ5 composite presence
         d.cpres = q.c_seen || (q.s2.csync != q.s3.csync);
      end else begin
         d.h_high = q.h_high + {13'h0000, sel_lvl};
         d.v_high = q.v_high + {13'h0000, q.s2.vsync};
         d.c_seen = q.c_seen || (q.s2.csync != q.s3.csync);
      end

      // counter step rate from c.3
      // RQ19 counter clock source
      cnt_step = 1'b1;
      if (q.c_ctl[0]) begin
         cnt_step = (q.presc == PRESC_LAST);
      end
      d.presc = q.presc + 3'h1;

      // RQ11 saturating up/down counter
      if (q.a_ctl[0] && cnt_step) begin
         if (sel_lvl && q.cnt != CNT_MAX) begin
            d.cnt = q.cnt + 5'h01;
         end else if (!sel_lvl && q.cnt != CNT_MIN) begin
            d.cnt = q.cnt - 5'h01;
         end
      end
      // RQ10 RQ20 extracted level at limits only
      if (q.cnt == CNT_MAX) begin
         d.ext_v = 1'b1;
      end else if (q.cnt == CNT_MIN) begin
         d.ext_v = 1'b0;
      end

      // RQ16 csync delay line
      d.c_dly   = {q.c_dly[SOG_DLY_CYC-2:0], q.s2.csync};
      c_dly_out = q.c_dly[SOG_DLY_CYC-1];
      h_rise    = q.s2.hsync && !q.s3.hsync;
      c_fall    = !q.s2.csync && q.s3.csync;

      // outputs
      vsel = q.a_ctl[0] ? q.ext_v : q.s2.vsync;
      d.outs.hsync_out = out_en && sel_lvl;
      d.outs.vsync_out = out_en && vsel;
      // RQ3 first capture timer on vsync output rise
      d.outs.capture_first = vsel && !q.outs.vsync_out && out_en;
      // RQ4 second timer clock from selected input
      d.outs.second_clk = sel_lvl;

      // RQ13 RQ14 clamp start: csync trailing edge or hsync rise
      clamp_start = q.green ? c_fall : h_rise;
      if (clamp_start) begin
         d.clamp_cnt = q.clamp_w;
      end else if (q.clamp_cnt != 8'h00) begin
         d.clamp_cnt = q.clamp_cnt - 8'h01;
      end
      // RQ15 clamp polarity
      d.outs.clamp_out = (d.clamp_cnt != 8'h00) ~^ q.b_ctl[2];

      // bus writes
      if (wr_stb) begin
         unique case (addr)
            ADDR_CTRL_A: begin
               d.a_ctl = {wdata[A_SRC_SEL], wdata[A_SPARE], wdata[A_CMP_MODE]};
            end
            ADDR_CTRL_B: begin
               d.b_ctl = wdata[7:2];
            end
            ADDR_CTRL_C: begin
               d.c_ctl = {wdata[C_VDD_SEL], wdata[C_OUT_EN], wdata[C_PSEUDO], wdata[C_CNT_SRC]};
               if (!wdata[C_GREEN]) begin
                  d.green   = 1'b0;
                  d.sog_cnt = 6'h00;
               end
            end
            ADDR_CLAMP_WIDTH: begin
               d.clamp_w = wdata;
            end
            default: begin
            end
         endcase
      end

      // RQ17 mismatch count, set wins over clear
      if (h_rise && !c_dly_out) begin
         if (q.sog_cnt != SOG_MAX) begin
            d.sog_cnt = q.sog_cnt + 6'h01;
         end
         if (q.sog_cnt >= 6'(SOG_LIMIT)) begin
            d.green = 1'b1;
         end
      end

      // bus reads, answered next cycle
      d.rdata = 8'h00;
      if (rd_stb) begin
         unique case (addr)
            ADDR_CTRL_A: begin
               // RQ21 counter readback
               d.rdata = {q.a_ctl[2], q.a_ctl[1], q.a_ctl[0], q.cnt};
            end
            ADDR_CTRL_B: begin
               d.rdata = {q.b_ctl, q.vpol, q.hpol};
            end
            ADDR_CTRL_C: begin
               d.rdata = {1'b0, q.c_ctl[3:1], q.c_ctl[0], q.green, q.cpres, 1'b0};
            end
            ADDR_CLAMP_WIDTH: begin
               d.rdata = q.clamp_w;
            end
            ADDR_PIN_LEVEL: begin
               d.rdata = {5'h00, q.ext_v, sel_lvl, q.s2.vsync};
            end
            default: begin
               d.rdata = 8'h00;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         q         <= '0;
         q.a_ctl   <= {RST_CTRL_A[A_SRC_SEL], RST_CTRL_A[A_SPARE], RST_CTRL_A[A_CMP_MODE]};
         q.b_ctl   <= RST_CTRL_B[7:2];
         q.c_ctl   <= {RST_CTRL_C[C_VDD_SEL], RST_CTRL_C[C_OUT_EN], RST_CTRL_C[C_PSEUDO],
                       RST_CTRL_C[C_CNT_SRC]};
         q.clamp_w <= RST_CLAMP_W;
         q.outs.clamp_out <= ~RST_CTRL_B[B_CLAMP_POL];
      end else begin
         q <= d;
      end
   end

   assign rdata         = q.rdata;
   assign sync_out      = q.outs;
   assign pseudo_en     = q.c_ctl[1];
   assign vdd_level_sel = q.c_ctl[3];

   // checks
   // RQ11 counter saturation
   cnt_saturate_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // RQ11
      q.cnt == CNT_MAX && sel_lvl && !(wr_stb && addr == ADDR_CTRL_A) |=> q.cnt == CNT_MAX)
      else $error("counter wrapped above maximum");
   // RQ11 counter floor
   cnt_floor_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // RQ11
      q.cnt == CNT_MIN && !sel_lvl |=> q.cnt == CNT_MIN)
      else $error("counter borrowed below minimum");
   // RQ20 extracted level at limits
   ext_high_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // RQ20
      q.cnt == CNT_MAX |=> q.ext_v)
      else $error("extracted level not high at maximum");
   ext_low_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // RQ20
      q.cnt == CNT_MIN |=> !q.ext_v)
      else $error("extracted level not low at minimum");
   // RQ10 hold between limits
   ext_hold_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // RQ10
      q.cnt != CNT_MAX && q.cnt != CNT_MIN |=> $stable(q.ext_v))
      else $error("extracted level moved between limits");
   // RQ6 polarity changes only at window end
   pol_window_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // RQ6
      !win_end |=> $stable(q.hpol) && $stable(q.vpol))
      else $error("polarity changed inside window");
   // RQ17 green flag needs enough mismatches
   green_set_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // RQ17
      $rose(q.green) |-> $past(q.sog_cnt) >= 6'(SOG_LIMIT))
      else $error("green flag set too early");
   // RQ15 clamp idle level follows polarity bit
   clamp_idle_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // RQ15
      q.clamp_cnt == 8'h00 && !$past(clamp_start) ##0 $stable(q.b_ctl) |->
      q.outs.clamp_out == !q.b_ctl[2])
      else $error("clamp idle level wrong");
   // RQ21 counter readback one cycle later
   cnt_read_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // RQ21
      rd_stb && addr == ADDR_CTRL_A |=> rdata[4:0] == $past(q.cnt))
      else $error("counter readback mismatch");
   // RQ3 capture pulse only with output rise
   capture_first_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // RQ3
      q.outs.capture_first |-> q.outs.vsync_out && !$past(q.outs.vsync_out))
      else $error("capture pulse without vsync rise");
endmodule

// ===== test/sdc_src_model.sv
// video source model driving the sync pins
`timescale 1ns/10ps
module sdc_src_model
   import sdc_pkg::*;
(
   input  wire logic         ref_clk,
   input  wire logic         run,
   input  wire logic         green_embedded_sync,
   input  wire logic [2:0]   lvl,
   output sdc_pins_type      pins
);
   int ph = 0;
   initial pins = '0;
   always @(posedge ref_clk) begin
      ph <= (ph + 1) % 40;
      if (run) begin
         pins.hsync <= (ph < 8);
         pins.csync <= green_embedded_sync ? (ph < 8) : (ph >= 34 || ph < 10);
         pins.vsync <= lvl[1];
      end else begin
         pins <= lvl;
      end
   end
endmodule

// ===== test/sdc_unit_tb.sv
// self-checking bench for the sync unit
`timescale 1ns/10ps
module sdc_unit_tb;
   import sdc_pkg::*;
   logic         ref_clk = 1'h0;
   logic         reset_n = 1'h0;
   logic         wr_stb = 1'h0;
   logic         rd_stb = 1'h0;
   logic         run = 1'h0;
   logic         green_embedded_sync = 1'h0;
   logic         hq = 1'h0;
   logic         pe;
   logic         vs;
   logic [7:0]   addr = 8'h00;
   logic [7:0]   wdata = 8'h00;
   logic [7:0]   rdata;
   logic [7:0]   d;
   logic [7:0]   w;
   logic [2:0]   lvl = 3'h0;
   sdc_pins_type pins;
   sdc_outs_type outs;
   int           fail_count = 0;
   int           n_checks = 0;
   int           mism = 0;
   int           caps = 0;
   int           n;
   logic [7:0]   ra[5] = '{ADDR_CTRL_A, ADDR_CTRL_B, ADDR_CTRL_C, ADDR_CLAMP_WIDTH, 8'h10};
   logic [7:0]   rv[5] = '{RST_CTRL_A, RST_CTRL_B, RST_CTRL_C, RST_CLAMP_W, 8'h00};
   initial forever #25 ref_clk = ~ref_clk;
   sdc_src_model src_u (.ref_clk(ref_clk), .run(run), .green_embedded_sync(green_embedded_sync), .lvl(lvl), .pins(pins));
   sdc_unit dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr_stb(wr_stb),
      .rd_stb(rd_stb), .rdata(rdata), .sync_in(pins), .sync_out(outs), .pseudo_en(pe), .vdd_level_sel(vs));
   // reference counts of green mismatches and captures
   always @(posedge ref_clk) begin
      hq <= pins.hsync;
      caps <= caps + int'(outs.capture_first === 1'h1);
      if (run && green_embedded_sync && pins.hsync && !hq)
         mism <= mism + 1;
   end
   task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
      n_checks++;
      if (g !== e) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge ref_clk);
      wr_stb <= 1'h1;
      addr <= a;
      wdata <= v;
      @(posedge ref_clk);
      wr_stb <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge ref_clk);
      rd_stb <= 1'h1;
      addr <= a;
      @(posedge ref_clk);
      rd_stb <= 1'h0;
      #1 d = rdata;
   endtask
   task automatic summarize;
      $display("checks %0d errors %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial begin
      void'($urandom(16));
      repeat (20) @(posedge ref_clk);
      reset_n <= 1'h1;
      wr(8'h10, 8'hff);
      foreach (ra[i]) begin
         rd(ra[i]);
         chk("reset", rv[i], d);
      end
      for (int k = 0; k < 16; k++) begin
         logic s;
         s = k[3] ? k[2] : k[0];
         wr(ADDR_CTRL_A, {k[3], 7'h00});
         lvl <= k[2:0];
         repeat (6) @(posedge ref_clk);
         chk("route", 8'({s, s, k[1]}), 8'({outs.hsync_out, outs.second_clk, outs.vsync_out}));
         rd(ADDR_PIN_LEVEL);
         chk("pins", 8'({s, k[1]}), d);
      end
      chk("caps", 8'h04, 8'(caps));
      wr(ADDR_CTRL_C, 8'h50);
      repeat (4) @(posedge ref_clk);
      chk("off", 8'h03, 8'({outs.hsync_out, outs.vsync_out, pe, vs}));
      wr(ADDR_CTRL_C, 8'h20);
      repeat (4) @(posedge ref_clk);
      chk("on", 8'h0c, 8'({outs.hsync_out, outs.vsync_out, pe, vs}));
      wr(ADDR_CTRL_A, 8'h20);
      repeat (40) @(posedge ref_clk);
      rd(ADDR_CTRL_A);
      chk("ceil", 8'h3f, d);
      chk("ext1", 8'h01, 8'(outs.vsync_out));
      chk("second", 8'h01, 8'(outs.second_clk));
      lvl <= 3'h0;
      repeat (10) @(posedge ref_clk);
      rd(ADDR_CTRL_A);
      chk("hold", 8'h07, 8'({d[4:0] > 0, d[4:0] < 31, outs.vsync_out}));
      repeat (40) @(posedge ref_clk);
      rd(ADDR_CTRL_A);
      chk("floor", 8'h20, d);
      chk("ext0", 8'h00, 8'(outs.vsync_out));
      wr(ADDR_CTRL_A, 8'h00);
      wr(ADDR_CTRL_C, 8'h20);
      w = 8'($urandom_range(20, 1));
      wr(ADDR_CLAMP_WIDTH, w);
      rd(ADDR_CLAMP_WIDTH);
      chk("width", w, d);
      run <= 1'h1;
      for (int p = 0; p < 2; p++) begin
         wr(ADDR_CTRL_B, {3'h0, p[0], 4'h0});
         repeat (40) @(posedge ref_clk);
         n = 0;
         repeat (40) @(posedge ref_clk) n += int'(outs.clamp_out === p[0]);
         chk("clamp", w, 8'(n));
      end
      rd(ADDR_CTRL_C);
      chk("nogreen", 8'h00, d & 8'h04);
      run <= 1'h0;
      repeat (4) @(posedge ref_clk);
      wr(ADDR_CTRL_C, 8'h20);
      mism = 0;
      green_embedded_sync <= 1'h1;
      run <= 1'h1;
      n = 0;
      while (mism < SOG_LIMIT && n < 5000) begin
         @(posedge ref_clk);
         n++;
      end
      if (n >= 5000) begin
         fail_count++;
         $display("ERROR mismatch_wait expected %0d seen %0d", SOG_LIMIT, mism);
         summarize;
      end
      rd(ADDR_CTRL_C);
      chk("green32", 8'h00, d & 8'h04);
      n = 0;
      do begin
         rd(ADDR_CTRL_C);
         n++;
      end while (d[2] !== 1'h1 && n < 500);
      if (n == 500) begin
         fail_count++;
         $display("ERROR green_poll expected %h seen %h", 8'h04, d & 8'h04);
         summarize;
      end
      chk("green33", 8'(SOG_LIMIT + 1), 8'(mism));
      green_embedded_sync <= 1'h0;
      wr(ADDR_CTRL_C, 8'h20);
      for (int v = 1; v >= 0; v--) begin
         lvl <= 3'(v * 2);
         repeat (2 * POL_TICKS * TICK_DIV) @(posedge ref_clk);
         wr(ADDR_CTRL_B, 8'hff);
         rd(ADDR_CTRL_B);
         chk("pol", {6'h3f, v == 0, 1'h1}, d);
      end
      rd(ADDR_CTRL_C);
      chk("cpres", 8'h22, d);
      summarize;
   end
endmodule
